// file: iosad_decoder.sv
`timescale 1ns/1ns
module iosad_decoder (
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic op_valid, // Core issues an I/O access this cycle.
    input wire iosad_pkg::iosad_op_t op_code, // Instruction class.
    input wire logic [15:0] op_addr, // I/O address or data-space address.
    input wire logic [2:0] op_bit, // Bit number for bit and skip ops.
    input wire logic [7:0] op_wdata, // Store or port write data.
    input wire logic [7:0] flag_set, // Events for the clear-on-one flags.
    input wire logic [7:0] per_rdata, // Peripheral read data, same cycle.
    output logic per_wr, // Peripheral write strobe.
    output logic per_rd, // Peripheral read strobe.
    output logic [7:0] per_addr, // Peripheral I/O address.
    output logic [7:0] per_wdata, // Peripheral write data.
    output logic [7:0] per_wmask, // Bits the peripheral may update.
    output logic done, // One-cycle pulse, access finished.
    output logic fault, // With done, access was refused.
    output logic skip, // With done, skip condition is true.
    output logic [7:0] rd_data, // With done, read result.
    output logic [7:0] flags // Clear-on-one status flags.
);
    typedef struct packed {
        logic s1_vld;
        logic s1_bad;
        logic s1_wr;
        logic s1_rd;
        logic s1_skip;
        logic s1_skip_hi;
        logic [2:0] s1_bit;
        logic [7:0] s1_addr;
        logic [7:0] s1_wdata;
        logic [7:0] s1_wmask;
        logic done;
        logic fault;
        logic skip;
        logic [7:0] rdata;
    } iosad_core_t;

    iosad_core_t state_ff;
    iosad_core_t nxt_state;
    logic flag_hit;
    logic [7:0] rd_mux;

    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = iosad_pkg::BIT_ONE << b;
    endfunction

    function automatic logic is_port(input iosad_pkg::iosad_op_t op);
        is_port = (op == iosad_pkg::OP_PORT_READ) ||
                  (op == iosad_pkg::OP_PORT_WRITE);
    endfunction

    function automatic logic is_bitop(input iosad_pkg::iosad_op_t op);
        is_bitop = (op == iosad_pkg::OP_BIT_SET) ||
                   (op == iosad_pkg::OP_BIT_CLEAR) ||
                   (op == iosad_pkg::OP_SKIP_HIGH) ||
                   (op == iosad_pkg::OP_SKIP_LOW);
    endfunction

    function automatic logic is_data_rd(input iosad_pkg::iosad_op_t op);
        is_data_rd = (op == iosad_pkg::OP_READ_POINTER) ||
                     (op == iosad_pkg::OP_READ_ABSOLUTE) ||
                     (op == iosad_pkg::OP_READ_OFFSET);
    endfunction

    function automatic logic is_data_wr(input iosad_pkg::iosad_op_t op);
        is_data_wr = (op == iosad_pkg::OP_WRITE_POINTER) ||
                     (op == iosad_pkg::OP_WRITE_ABSOLUTE) ||
                     (op == iosad_pkg::OP_WRITE_OFFSET);
    endfunction

    // The flag byte answers at its own address in place of a peripheral.
    assign flag_hit = state_ff.s1_addr == iosad_pkg::FLAG_IO_ADDR;
    assign rd_mux = flag_hit ? flags : per_rdata;

    logic flags_wr_seen;
    assign flags_wr_seen = state_ff.s1_wr && flag_hit;

    always_comb begin
        logic ok;
        logic wr;
        logic rd;
        logic [7:0] io_addr;
        logic [7:0] wdat;
        logic [7:0] wmsk;
        ok = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        io_addr = op_addr[7:0];
        wdat = op_wdata;
        wmsk = iosad_pkg::BYTE_ALL;
        nxt_state = state_ff;
        case (op_code)
            iosad_pkg::OP_PORT_READ, iosad_pkg::OP_PORT_WRITE: begin
                // Port ops carry a 6-bit field; nothing above it is reached.
                ok = op_addr <=
                     {8'h00, iosad_pkg::IO_PORT_MAX}; // [R4] [R6] [R7]
                wr = op_code == iosad_pkg::OP_PORT_WRITE;
                rd = !wr;
            end
            iosad_pkg::OP_BIT_SET, iosad_pkg::OP_BIT_CLEAR: begin
                ok = op_addr <= {8'h00, iosad_pkg::IO_BIT_MAX}; // [R3]
                wr = 1'b1;
                // Only the addressed bit is written, so no read-modify-write
                // can clear a neighbouring flag by accident.
                wmsk = bit_mask(op_bit); // [R2]
                wdat = (op_code == iosad_pkg::OP_BIT_SET) ? wmsk :
                       iosad_pkg::BYTE_ZERO; // [R2]
            end
            iosad_pkg::OP_SKIP_HIGH, iosad_pkg::OP_SKIP_LOW: begin
                ok = op_addr <= {8'h00, iosad_pkg::IO_BIT_MAX}; // [R9]
                rd = 1'b1;
            end
            default: begin
                // Load and store see the whole I/O space shifted by 0x20.
                ok = (is_data_rd(op_code) || is_data_wr(op_code)) &&
                     op_addr >= iosad_pkg::DATA_IO_LO &&
                     op_addr <= iosad_pkg::DATA_IO_HI; // [R7]
                io_addr = op_addr[7:0] - iosad_pkg::DATA_IO_OFS; // [R5]
                wr = is_data_wr(op_code);
                rd = is_data_rd(op_code);
            end
        endcase
        nxt_state.s1_vld = op_valid;
        nxt_state.s1_bad = op_valid && !ok; // [R10]
        nxt_state.s1_wr = op_valid && ok && wr; // [R10]
        nxt_state.s1_rd = op_valid && ok && rd;
        nxt_state.s1_skip = op_code == iosad_pkg::OP_SKIP_HIGH ||
                            op_code == iosad_pkg::OP_SKIP_LOW;
        nxt_state.s1_skip_hi = op_code == iosad_pkg::OP_SKIP_HIGH;
        nxt_state.s1_bit = op_bit;
        nxt_state.s1_addr = io_addr;
        nxt_state.s1_wdata = wdat;
        nxt_state.s1_wmask = wmsk;
        nxt_state.done = state_ff.s1_vld;
        nxt_state.fault = state_ff.s1_bad;
        nxt_state.skip = 1'b0;
        if (state_ff.s1_rd) begin
            nxt_state.rdata = rd_mux;
            nxt_state.skip = state_ff.s1_skip &&
                (|(rd_mux & bit_mask(state_ff.s1_bit)) ==
                 state_ff.s1_skip_hi); // [R9]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    iosad_flags u_flags (
        .clk(clk),
        .rst(rst),
        .set_in(flag_set),
        .wr(flags_wr_seen),
        .wdata(state_ff.s1_wdata),
        .wmask(state_ff.s1_wmask),
        .flags(flags)
    );

    assign per_wr = state_ff.s1_wr && !flag_hit;
    assign per_rd = state_ff.s1_rd && !flag_hit;
    assign per_addr = state_ff.s1_addr;
    assign per_wdata = state_ff.s1_wdata;
    assign per_wmask = state_ff.s1_wmask;
    assign done = state_ff.done;
    assign fault = state_ff.fault;
    assign skip = state_ff.skip;
    assign rd_data = state_ff.rdata;

    sequence s_bitop_far;
        op_valid && (op_code == iosad_pkg::OP_BIT_SET ||
            op_code == iosad_pkg::OP_BIT_CLEAR) &&
            op_addr > 16'(iosad_pkg::IO_BIT_MAX);
    endsequence

    sequence s_refused;
        !per_wr && !flags_wr_seen ##1 done && fault;
    endsequence

    a_bit_range: assert property (@(posedge clk) disable iff (rst) // [R3]
        s_bitop_far |=> s_refused)
        else $error("bit op outside 0x00-0x1f was not refused");

    a_port_window: assert property (@(posedge clk) disable iff (rst) // [R6]
        op_valid && is_port(op_code) &&
        op_addr > 16'(iosad_pkg::IO_PORT_MAX) |=> s_refused)
        else $error("port op outside 64 locations was not refused");

    a_port_addr: assert property (@(posedge clk) disable iff (rst) // [R4]
        op_valid && is_port(op_code) &&
        op_addr <= 16'(iosad_pkg::IO_PORT_MAX)
        |=> (per_wr || per_rd || flag_hit) && per_addr == $past(op_addr[7:0]))
        else $error("port op did not reach its I/O address");

    // The fault bit of the cycle after a request belongs to the request
    // before it, so fault is looked at only together with this done.
    a_data_offset: assert property (@(posedge clk) disable iff (rst) // [R5]
        op_valid && is_data_wr(op_code) &&
        op_addr >= iosad_pkg::DATA_IO_LO && op_addr <= iosad_pkg::DATA_IO_HI
        |=> (per_wr || flags_wr_seen) &&
        per_addr == $past(op_addr[7:0]) - iosad_pkg::DATA_IO_OFS
        ##1 done && !fault)
        else $error("store did not map data address minus 0x20");

    a_ext_load: assert property (@(posedge clk) disable iff (rst) // [R7]
        op_valid && is_data_rd(op_code) &&
        op_addr >= iosad_pkg::DATA_EXT_LO && op_addr <= iosad_pkg::DATA_IO_HI
        |=> per_rd ##1 done && !fault)
        else $error("extended region not readable by load");

    a_one_bit: assert property (@(posedge clk) disable iff (rst) // [R2]
        op_valid && is_bitop(op_code) &&
        op_addr <= 16'(iosad_pkg::IO_BIT_MAX) &&
        op_code inside {iosad_pkg::OP_BIT_SET, iosad_pkg::OP_BIT_CLEAR}
        |=> $onehot(per_wmask) &&
        per_wmask == (iosad_pkg::BIT_ONE << $past(op_bit)))
        else $error("bit op touched more than the addressed bit");

    // A hardware event in the clearing cycle keeps its flag set.
    a_w1c_clear: assert property (@(posedge clk) disable iff (rst) // [R1]
        flags_wr_seen &&
        ((state_ff.s1_wdata & state_ff.s1_wmask) != iosad_pkg::BYTE_ZERO)
        |=> ((flags & $past(state_ff.s1_wdata & state_ff.s1_wmask)
        & ~$past(flag_set)) == iosad_pkg::BYTE_ZERO) &&
        ((flags & $past(flags)) == ($past(flags) &
        (~$past(state_ff.s1_wdata & state_ff.s1_wmask) | $past(flag_set)))))
        else $error("clear-on-one flag write misbehaved");

    a_skip_test: assert property (@(posedge clk) disable iff (rst) // [R9]
        state_ff.s1_rd && state_ff.s1_skip
        |=> done && skip == ($past(rd_mux[state_ff.s1_bit]) ==
        $past(state_ff.s1_skip_hi)))
        else $error("skip result does not match tested bit");

    a_bad_no_write: assert property (@(posedge clk) disable iff (rst) // [R10]
        state_ff.s1_bad |-> !per_wr && !flags_wr_seen ##1 done && fault)
        else $error("refused access wrote a peripheral");
endmodule

// file: iosad_flags.sv
// Summary of operation
// [R1] A status flag clears when a one is written to it; zero leaves it.
// [R2] Bit set and bit clear write only the addressed bit, never the others.
// [R3] Single-bit set and clear act only on I/O addresses 0x00 to 0x1f.
// [R4] Port read and port write use I/O addresses 0x00 through 0x3f.
// [R5] Load and store reach an I/O register at its I/O address plus 0x20.
// [R6] Port instructions reach nothing outside the 64-entry I/O window.
// [R7] Extended region 0x60 to 0xff is reached only by load and store.
// [R8] Software writes reserved bits as zero, never reserved addresses.
// [R9] In I/O addresses 0x00 to 0x1f a single bit can be tested by skips.
// [R10] An address outside its class range causes no peripheral write.
`timescale 1ns/1ns
package iosad_pkg;
    localparam logic [7:0] IO_BIT_MAX = 8'h1f;
    localparam logic [7:0] IO_PORT_MAX = 8'h3f;
    localparam logic [15:0] DATA_IO_LO = 16'h0020;
    localparam logic [15:0] DATA_IO_HI = 16'h00ff;
    localparam logic [15:0] DATA_EXT_LO = 16'h0060;
    localparam logic [7:0] DATA_IO_OFS = 8'h20;
    localparam logic [7:0] FLAG_IO_ADDR = 8'h16;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ALL = 8'hff;
    localparam logic [7:0] BIT_ONE = 8'h01;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_PORT_READ = 4'b0001,
        OP_PORT_WRITE = 4'b0010,
        OP_BIT_SET = 4'b0011,
        OP_BIT_CLEAR = 4'b0100,
        OP_SKIP_HIGH = 4'b0101,
        OP_SKIP_LOW = 4'b0110,
        OP_READ_POINTER = 4'b0111,
        OP_WRITE_POINTER = 4'b1000,
        OP_READ_ABSOLUTE = 4'b1001,
        OP_WRITE_ABSOLUTE = 4'b1010,
        OP_READ_OFFSET = 4'b1011,
        OP_WRITE_OFFSET = 4'b1100
    } iosad_op_t;
endpackage

module iosad_flags (
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [7:0] set_in, // Hardware events, one per flag.
    input wire logic wr, // Write strobe from the decoder.
    input wire logic [7:0] wdata, // Write data.
    input wire logic [7:0] wmask, // Bits that the write really touches.
    output logic [7:0] flags // Current flag state.
);
    typedef struct packed {
        logic [7:0] flags;
    } iosad_flag_t;

    iosad_flag_t state_ff;
    iosad_flag_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        // A new event in the clearing cycle survives, so no event is lost.
        nxt_state.flags = state_ff.flags &
            ~(wr ? (wdata & wmask) : iosad_pkg::BYTE_ZERO); // [R1]
        nxt_state.flags = nxt_state.flags | set_in; // [R1]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff.flags <= iosad_pkg::FLAG_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flags = state_ff.flags;
endmodule

// file: iosad_periph_model.sv
`timescale 1ns/1ns
module iosad_periph_model (
    input wire logic clk, // System clock.
    input wire logic per_wr, // Write strobe.
    input wire logic per_rd, // Read strobe.
    input wire logic [7:0] per_addr, // Register address.
    input wire logic [7:0] per_wdata, // Write data.
    input wire logic [7:0] per_wmask, // Bits to update.
    output logic [7:0] per_rdata // Read data.
);
    logic [7:0] mem [0:255];
    logic [7:0] junk = 8'h3c;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
    // Outside a read the bus moves every cycle, so a stale sample shows.
    assign per_rdata = per_rd ? mem[per_addr] : junk;
    always @(posedge clk) begin
        junk <= ~junk + 8'h11;
        if (per_wr) mem[per_addr] <= (mem[per_addr] & ~per_wmask) |
            (per_wdata & per_wmask);
    end
endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic v, f, wr, rd, isr, sk;
        logic [7:0] a, w, m, rdv;
    } iosad_exp_t;
    logic clk, rst, op_valid;
    iosad_pkg::iosad_op_t op_code;
    logic [15:0] op_addr, a;
    logic [2:0] op_bit;
    logic [7:0] op_wdata, flag_set, per_rdata, fm;
    logic [7:0] per_addr, per_wdata, per_wmask, rd_data, flags;
    logic per_wr, per_rd, done, fault, skip;
    logic [7:0] mem [0:255];
    iosad_exp_t s1, s2;
    int fail_count, n_tests;
    int edges[8] = '{'h1f, 'h20, 'h3f, 'h40, 'h5f, 'h60, 'hff, 'h100};

    iosad_decoder u_dut (.clk(clk), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit),
        .op_wdata(op_wdata), .flag_set(flag_set), .per_rdata(per_rdata),
        .per_wr(per_wr), .per_rd(per_rd), .per_addr(per_addr),
        .per_wdata(per_wdata), .per_wmask(per_wmask), .done(done),
        .fault(fault), .skip(skip), .rd_data(rd_data), .flags(flags));
    iosad_periph_model u_per (.clk(clk), .per_wr(per_wr), .per_rd(per_rd),
        .per_addr(per_addr), .per_wdata(per_wdata),
        .per_wmask(per_wmask), .per_rdata(per_rdata));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    // Checks the two pipeline stages, then issues the next request.
    task automatic step(input logic v, input logic [3:0] op,
                        input logic [15:0] ad, input logic [2:0] b,
                        input logic [7:0] d);
        iosad_exp_t e;
        logic ok, fl;
        logic [7:0] io, rv;
        @(negedge clk);
        chk1(per_wr, s1.v && s1.wr);
        chk1(per_rd, s1.v && s1.rd);
        if (s1.wr || s1.rd) chk8(per_addr, s1.a);
        if (s1.wr) chk8(per_wdata, s1.w);
        if (s1.wr) chk8(per_wmask, s1.m);
        chk1(done, s2.v);
        if (s2.v) chk1(fault, s2.f);
        if (s2.v && !s2.f) chk1(skip, s2.sk);
        if (s2.v && !s2.f && s2.isr) chk8(rd_data, s2.rdv);
        op_valid = v;
        op_code = iosad_pkg::iosad_op_t'(op);
        op_addr = ad;
        op_bit = b;
        op_wdata = d;
        e = '0;
        io = ad[7:0];
        case (op)
            1, 2: ok = ad <= 16'h3f;
            3, 4, 5, 6: ok = ad <= 16'h1f;
            7, 8, 9, 10, 11, 12: begin
                ok = ad >= 16'h20 && ad <= 16'hff;
                io = ad[7:0] - 8'h20;
            end
            default: ok = 1'b0;
        endcase
        fl = ok && io == 8'h16;
        e.v = v;
        e.f = !ok;
        e.isr = op inside {1, 5, 6, 7, 9, 11};
        e.wr = ok && !fl && op inside {2, 3, 4, 8, 10, 12};
        e.rd = ok && !fl && e.isr;
        e.a = io;
        e.m = op inside {3, 4} ? 8'h01 << b : 8'hff;
        e.w = op == 3 ? e.m : (op == 4 ? 8'h00 : d);
        rv = fl ? fm : mem[io];
        e.rdv = rv;
        e.sk = op == 5 ? rv[b] : (op == 6 ? !rv[b] : 1'b0);
        if (v && e.wr) mem[io] = (mem[io] & ~e.m) | (e.w & e.m);
        if (v && fl && op inside {2, 3, 4, 8, 10, 12}) fm = fm & ~(e.w & e.m);
        s2 = s1;
        s1 = e;
    endtask

    task automatic fstep(input logic [3:0] op, input logic [15:0] ad,
                         input logic [2:0] b, input logic [7:0] d);
        step(1, op, ad, b, d);
        repeat (3) step(0, 0, 0, 0, 0);
        chk8(flags, fm);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #40000;
        fail_count++;
        close_out();
    end

    initial begin
        rst = 1;
        op_valid = 0;
        op_code = iosad_pkg::OP_NONE;
        op_addr = 0;
        op_bit = 0;
        op_wdata = 0;
        flag_set = 0;
        s1 = '0;
        s2 = '0;
        fm = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
        void'($urandom(66869));
        repeat (12) @(negedge clk);
        rst = 0;
        chk8(flags, 8'h00);
        foreach (edges[j]) for (int op = 0; op < 13; op++) begin
            step(1, 4'(op), 16'(edges[j]), 3'(op), 8'h5a ^ 8'(j));
        end
        repeat (300) begin
            a = 16'($urandom_range(0, 'h11f));
            if (a[7:0] == 8'h16 || a[7:0] == 8'h36) a = 16'h17;
            step($urandom_range(0, 7) != 0, 4'($urandom_range(0, 12)), a,
                 3'($urandom), 8'($urandom));
        end
        flag_set = 8'hff;
        step(0, 0, 0, 0, 0);
        flag_set = 8'h00;
        fm = 8'hff;
        fstep(2, 16'h16, 0, 8'h05);
        fstep(3, 16'h16, 7, 0);
        fstep(4, 16'h16, 1, 0);
        fstep(10, 16'h36, 0, 8'h02);
        fstep(5, 16'h16, 4, 0);
        // The event lands on the very edge that applies the clearing write.
        step(1, 2, 16'h16, 0, 8'h88);
        step(0, 0, 0, 0, 0);
        flag_set = 8'h80;
        step(0, 0, 0, 0, 0);
        flag_set = 8'h00;
        fm = fm | 8'h80;
        fstep(0, 0, 0, 0);
        close_out();
    end
endmodule
